//--- rtl/tpg_security_gate.sv
// Test-port access gate: lock, sector protection, blank state and port enable
//
// Local design decisions: the Wishbone slave port and the address map.
`timescale 1ns/10ps
// How it works
// - Lock set: every memory read refused
// - Lock set: only full-chip erase accepted
// - Lock set: program, erase, verify blocked
// - Full-chip erase done clears lock, sets blank
// - Protected sector: its erase refused
// - Blank state: memory and logic read ones
// - Blank state: configuration register reads zero
// - Enable bit zero turns port on/off
// - Dedicated pins: device reset ignored
// - Register-only enable: reset blocks, aborts operations
// - Port active when any source true
// - Enable bit cleared by reset or write
// - Data-out pin input until enable command, then output
module tpg_security_gate (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Nonvolatile configuration and programmable-logic term
	input  wire logic        nvmSecure,
	input  wire logic        nvmDedicate,
	input  wire logic [11:0] sectorProtect,
	input  wire logic        test_pins_product_term,
	// Device reset pin
	input  wire logic        devResetPin,
	// Serial test link pins
	input  wire logic        tckPin,
	input  wire logic        tmsPin,
	input  wire logic        tdiPin,
	output logic             tdoOut,
	output logic             tdoOe,
	output logic             portActive,
	// Memory controller side
	output logic             opStrobe,
	output logic      [3:0]  opCode,
	output logic      [3:0]  opSector,
	output logic             opRefused,
	output logic             opAbort,
	input  wire logic        opDone,
	input  wire logic [7:0]  memRdata,
	input  wire logic [7:0]  cfgRdata
);
	// Pin synchronisers: 0 tck, 1 tms, 2 tdi, 3 device reset
	logic [3:0] pinLevel;
	logic [3:0] pinRise;
	logic [3:0] pinFall;

	tpg_pin_sync #(.N(4)) u_sync (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.pinIn   ({devResetPin, tdiPin, tmsPin, tckPin}),
		.level   (pinLevel),
		.rise    (pinRise),
		.fall    (pinFall)
	);

	logic tckRise;
	logic tckFall;
	logic tmsLvl;
	logic tdiLvl;
	logic devRst;
	assign tckRise = pinRise[0];
	assign tckFall = pinFall[0];
	assign tmsLvl  = pinLevel[1];
	assign tdiLvl  = pinLevel[2];
	assign devRst  = pinLevel[3];

	logic       enable_q;
	logic       lockLoaded_q;
	logic       lock_q;
	logic       blank_q;
	logic       iscOn_q;
	logic       busy_q;
	logic [3:0] busyOp_q;
	logic [7:0] shift_q;
	logic [7:0] tdoShift_q;
	logic       ack_q;
	logic [31:0] rdata_q;

	// Port enable sources are ORed; otherwise pins are general I/O
	assign portActive = nvmDedicate | enable_q | test_pins_product_term;

	// Reset reaches the port only when the register alone enables it
	logic regOnly;
	logic resetBlock;
	assign regOnly    = enable_q & ~nvmDedicate & ~test_pins_product_term;
	assign resetBlock = devRst & ~nvmDedicate & ~test_pins_product_term;

	logic linkLive;
	assign linkLive = portActive & ~resetBlock;

	// Wishbone decode
	logic wbReq;
	logic wbWr;
	logic hitEnable;
	logic hitStatus;
	assign wbReq     = wb_cyc_i & wb_stb_i & ~ack_q;
	assign wbWr      = wbReq & wb_we_i;
	assign hitEnable = wb_adr_i == tpg_pkg::OFS_PORT_ENABLE;
	assign hitStatus = wb_adr_i == tpg_pkg::OFS_STATUS;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= wbReq;
		end
	end
	assign wb_ack_o = ack_q;

	// Port enable bit; unused bits 1..7 are not stored and read zero
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			enable_q <= tpg_pkg::PORT_ENABLE_RST[tpg_pkg::ENABLE_BIT];
		end else if (devRst) begin
			enable_q <= 1'b0;
		end else if (wbWr && hitEnable && wb_sel_i[0]) begin
			enable_q <= wb_dat_i[tpg_pkg::ENABLE_BIT];
		end
	end

	// Read data, registered with the acknowledge
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rdata_q <= 32'h0000_0000;
		end else if (wbReq && !wb_we_i) begin
			rdata_q <= 32'h0000_0000;
			if (hitEnable) begin
				rdata_q[tpg_pkg::ENABLE_BIT] <= enable_q;
			end else if (hitStatus) begin
				rdata_q[tpg_pkg::ST_LOCK_BIT]   <= lock_q;
				rdata_q[tpg_pkg::ST_BLANK_BIT]  <= blank_q;
				rdata_q[tpg_pkg::ST_ACTIVE_BIT] <= portActive;
				rdata_q[tpg_pkg::ST_TDOEN_BIT]  <= tdoOe;
				rdata_q[tpg_pkg::ST_BUSY_BIT]   <= busy_q;
			end
		end
	end
	assign wb_dat_o = rdata_q;

	// Command frame: shift on tck rise with tms low, execute on tck rise with tms high
	logic frameEnd;
	logic [3:0] frmOp;
	logic [3:0] frmSect;
	assign frameEnd = linkLive & tckRise & tmsLvl;
	assign frmOp    = shift_q[7:4];
	assign frmSect  = shift_q[3:0];

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			shift_q <= 8'h00;
		end else if (!linkLive) begin
			shift_q <= 8'h00;
		end else if (tckRise && !tmsLvl) begin
			shift_q <= {tdiLvl, shift_q[7:1]};
		end
	end

	// Protection decode for a sector index
	function automatic logic sectProtected(input logic [3:0] s, input logic [11:0] prot);
		sectProtected = (s < 4'(tpg_pkg::PRI_SECT + tpg_pkg::SEC_SECT)) ? prot[s] : 1'b1;
	endfunction

	// Accept or refuse a completed frame
	logic accept;
	logic isMemOp;
	always_comb begin
		accept  = 1'b0;
		isMemOp = 1'b0;
		unique case (frmOp)
			tpg_pkg::OP_CHIP_ERASE: begin
				accept  = iscOn_q & ~busy_q;
				isMemOp = 1'b1;
			end
			tpg_pkg::OP_READ, tpg_pkg::OP_CFG_READ, tpg_pkg::OP_VERIFY: begin
				accept  = iscOn_q & ~busy_q & ~lock_q;
				isMemOp = 1'b1;
			end
			tpg_pkg::OP_PROGRAM: begin
				accept  = iscOn_q & ~busy_q & ~lock_q;
				isMemOp = 1'b1;
			end
			tpg_pkg::OP_SECT_ERASE: begin
				accept  = iscOn_q & ~busy_q & ~lock_q & ~sectProtected(frmSect, sectorProtect);
				isMemOp = 1'b1;
			end
			default: begin
				accept  = 1'b0;
				isMemOp = 1'b0;
			end
		endcase
	end

	// Operation handoff to the memory controller
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			opStrobe  <= 1'b0;
			opRefused <= 1'b0;
			opCode    <= 4'h0;
			opSector  <= 4'h0;
		end else begin
			opStrobe  <= frameEnd & isMemOp & accept;
			opRefused <= frameEnd & isMemOp & ~accept;
			if (frameEnd && isMemOp && accept) begin
				opCode   <= frmOp;
				opSector <= frmSect;
			end
		end
	end

	// Busy tracking; reset on the register-only path aborts the operation
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			busy_q   <= 1'b0;
			busyOp_q <= 4'h0;
			opAbort  <= 1'b0;
		end else begin
			opAbort <= busy_q & resetBlock & regOnly;
			if (resetBlock && regOnly) begin
				busy_q <= 1'b0;
			end else if (frameEnd && isMemOp && accept) begin
				busy_q   <= 1'b1;
				busyOp_q <= frmOp;
			end else if (opDone) begin
				busy_q <= 1'b0;
			end
		end
	end

	// Lock is captured from the nonvolatile bit after reset release
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			lockLoaded_q <= 1'b0;
			lock_q       <= 1'b1;
			blank_q      <= 1'b0;
		end else if (!lockLoaded_q) begin
			lockLoaded_q <= 1'b1;
			lock_q       <= nvmSecure;
		end else if (busy_q && opDone && busyOp_q == tpg_pkg::OP_CHIP_ERASE && !(resetBlock && regOnly)) begin
			lock_q  <= 1'b0;
			blank_q <= 1'b1;
		end else if (opStrobe && opCode == tpg_pkg::OP_PROGRAM) begin
			blank_q <= 1'b0;
		end
	end

	// Enable command turns the data output on; disable or blocking reset turns it off
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			iscOn_q <= 1'b0;
		end else if (!linkLive) begin
			iscOn_q <= 1'b0;
		end else if (frameEnd && frmOp == tpg_pkg::OP_ISC_ENABLE) begin
			iscOn_q <= 1'b1;
		end else if (frameEnd && frmOp == tpg_pkg::OP_ISC_DISABL) begin
			iscOn_q <= 1'b0;
		end
	end

	// Read-back data, blank state forced and locked contents hidden
	logic [7:0] readBack;
	always_comb begin
		if (lock_q) begin
			readBack = 8'h00;
		end else if (blank_q && opCode == tpg_pkg::OP_CFG_READ) begin
			readBack = tpg_pkg::CFG_BLANK_VALUE;
		end else if (blank_q) begin
			readBack = tpg_pkg::MEM_BLANK_VALUE;
		end else if (opCode == tpg_pkg::OP_CFG_READ) begin
			readBack = cfgRdata;
		end else begin
			readBack = memRdata;
		end
	end

	// Serial data out: loaded on a completed read, shifted on tck fall
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			tdoShift_q <= 8'h00;
		end else if (busy_q && opDone && (busyOp_q == tpg_pkg::OP_READ || busyOp_q == tpg_pkg::OP_CFG_READ
				|| busyOp_q == tpg_pkg::OP_VERIFY)) begin
			tdoShift_q <= readBack;
		end else if (linkLive && tckFall) begin
			tdoShift_q <= {1'b0, tdoShift_q[7:1]};
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			tdoOut <= 1'b0;
		end else if (linkLive && tckFall) begin
			tdoOut <= tdoShift_q[0];
		end
	end
	assign tdoOe = iscOn_q & linkLive;
endmodule

//--- rtl/tpg_pkg.sv
// Constants shared by the test-port security gate
package tpg_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_PORT_ENABLE = 8'h00;
	localparam logic [7:0] OFS_STATUS      = 8'h04;
	// Field positions
	localparam int ENABLE_BIT     = 0;
	localparam int ST_LOCK_BIT    = 0;
	localparam int ST_BLANK_BIT   = 1;
	localparam int ST_ACTIVE_BIT  = 2;
	localparam int ST_TDOEN_BIT   = 3;
	localparam int ST_BUSY_BIT    = 4;
	// Reset and blank-state read values
	localparam logic [7:0] PORT_ENABLE_RST = 8'h00;
	localparam logic [7:0] CFG_BLANK_VALUE = 8'h00;
	localparam logic [7:0] MEM_BLANK_VALUE = 8'hff;
	// Frame layout: opcode in the upper nibble, sector in the lower
	localparam int FRAME_W  = 8;
	localparam int SECT_W   = 4;
	localparam int PRI_SECT = 8;
	localparam int SEC_SECT = 4;
	// Opcodes carried over the serial link
	typedef enum logic [3:0] {
		OP_NOP        = 4'h0,
		OP_ISC_ENABLE = 4'h1,
		OP_READ       = 4'h2,
		OP_PROGRAM    = 4'h3,
		OP_SECT_ERASE = 4'h4,
		OP_VERIFY     = 4'h5,
		OP_CHIP_ERASE = 4'h6,
		OP_ISC_DISABL = 4'h7,
		OP_CFG_READ   = 4'h8
	} tpg_op_e;
endpackage

//--- rtl/tpg_pin_sync.sv
// Two-stage synchronisers and edge detection for pins entering the clk_sys domain
`timescale 1ns/10ps
module tpg_pin_sync #(
	parameter int N = 4
) (
	// Clock and reset
	input  wire logic         clk_sys,
	input  wire logic         resetn,
	// Asynchronous pins
	input  wire logic [N-1:0] pinIn,
	// Synchronised levels and edges
	output logic      [N-1:0] level,
	output logic      [N-1:0] rise,
	output logic      [N-1:0] fall
);
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_bit
			logic meta_q;
			logic sync_q;
			logic prev_q;
			always_ff @(posedge clk_sys or negedge resetn) begin
				if (!resetn) begin
					meta_q <= 1'b0;
					sync_q <= 1'b0;
					prev_q <= 1'b0;
				end else begin
					meta_q <= pinIn[i];
					sync_q <= meta_q;
					prev_q <= sync_q;
				end
			end
			assign level[i] = sync_q;
			assign rise[i]  = sync_q & ~prev_q;
			assign fall[i]  = ~sync_q & prev_q;
		end
	endgenerate
endmodule

//--- tb/tpg_sva.sv
// Concurrent checks on the security gate ports
`timescale 1ns/10ps
module tpg_sva (
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        resetn,
	// Register bus
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic        wb_ack_o,
	// Enable sources, device reset and sector protection
	input wire logic        nvmDedicate,
	input wire logic        test_pins_product_term,
	input wire logic        devResetPin,
	input wire logic [11:0] sectorProtect,
	// Link and memory side
	input wire logic        tdoOe,
	input wire logic        portActive,
	input wire logic        opStrobe,
	input wire logic [3:0]  opCode,
	input wire logic [3:0]  opSector,
	input wire logic        opRefused,
	input wire logic        opAbort
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	a_ack_answer: assert property (take |=> wb_ack_o) else $error("ack missing after request");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
	a_enable_on: assert property (take && wb_we_i && wb_adr_i == tpg_pkg::OFS_PORT_ENABLE
		&& wb_sel_i[0] && wb_dat_i[0] && !$past(devResetPin) && !$past(devResetPin, 2)
		|-> ##2 portActive) else $error("port not on");
	a_active_src: assert property (nvmDedicate || test_pins_product_term |-> portActive)
		else $error("port off with a source high");
	a_oe_inactive: assert property (!portActive |-> !tdoOe)
		else $error("tdo driven while port off");
	a_one_verdict: assert property (!(opStrobe && opRefused))
		else $error("op both taken and refused");
	a_dedic_keep: assert property (nvmDedicate && $past(nvmDedicate) |-> !opAbort)
		else $error("abort with dedicated pins");
	a_prot_erase: assert property (opStrobe && opCode == tpg_pkg::OP_SECT_ERASE
		|-> opSector < 4'hc && !sectorProtect[opSector]) else $error("protected sector erased");
	c_refused: cover property (opRefused);
	c_abort: cover property (opAbort);
	c_chip_erase: cover property (opStrobe && opCode == tpg_pkg::OP_CHIP_ERASE);
endmodule
bind tpg_security_gate tpg_sva tpg_sva_i (.*);

//--- tb/tpg_prog_model.sv
// Serial test-port programmer model
`timescale 1ns/10ps
module tpg_prog_model (
	// Link pins
	output logic       tck,
	output logic       tms,
	output logic       tdi,
	input  wire logic  tdo,
	// Serial output bits seen during the last frame
	output logic [7:0] rx
);
	initial begin
		tck = 0;
		tms = 0;
		tdi = 0;
		rx  = 8'h00;
	end
	// Eight shift rises, LSB first, then one execute rise; clock idles low
	// Serial output is taken just before each rise but the first, long after the previous fall settled it
	task automatic send(input logic [7:0] f);
		for (int i = 0; i < 9; i++) begin
			tms = (i == 8);
			tdi = (i < 8) ? f[i] : ~tdi;
			#100;
			if (i > 0) rx[i-1] = tdo;
			tck = 1;
			#100 tck = 0;
		end
		tms = 0;
		tdi = ~tdi;
	endtask
endmodule

//--- tb/tpg_security_gate_tb.sv
// Self-checking bench for the test-port security gate
`timescale 1ns/10ps
module tpg_security_gate_tb;
	logic        clk_sys = 0, resetn = 0, cyc = 0, stb = 0, we = 0, sec = 1, ded = 0, term = 0;
	logic        devRst = 0, tck, tms, tdi, tdo, oe, act, stro, refu, abrt, done = 0;
	logic [7:0]  adr = 0, mem = 0, cfg = 0;
	logic [31:0] wdat = 0, rdat;
	logic [3:0]  sel = 0, code, sect;
	logic [11:0] prot = 0;
	logic        ack;
	logic [7:0]  rx;
	int          errCount = 0, checks = 0, nS = 0, nR = 0, nA = 0, bc = 0;
	logic [7:0]  lk [5] = '{8'h20, 8'h30, 8'h41, 8'h50, 8'h80};
	always #12.5 clk_sys = ~clk_sys;
	tpg_prog_model tpg_prog_model_i (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .rx(rx));
	tpg_security_gate tpg_security_gate_i (.clk_sys(clk_sys), .resetn(resetn), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
		.wb_dat_o(rdat), .wb_ack_o(ack), .nvmSecure(sec), .nvmDedicate(ded), .sectorProtect(prot),
		.test_pins_product_term(term), .devResetPin(devRst), .tckPin(tck), .tmsPin(tms),
		.tdiPin(tdi), .tdoOut(tdo), .tdoOe(oe), .portActive(act), .opStrobe(stro), .opCode(code),
		.opSector(sect), .opRefused(refu), .opAbort(abrt), .opDone(done), .memRdata(mem),
		.cfgRdata(cfg));
	// Memory controller stand-in: finishes an accepted op after 30 cycles
	always @(posedge clk_sys) begin
		nS <= nS + (stro === 1);
		nR <= nR + (refu === 1);
		nA <= nA + (abrt === 1);
		bc <= (stro === 1) ? 30 : (abrt === 1 || bc == 0) ? 0 : bc - 1;
		done <= (bc == 1);
		mem <= 8'($urandom);
		cfg <= 8'($urandom);
	end
	function automatic logic eraseOk(logic [11:0] p, int k);
		return k < 12 && !p[k];
	endfunction
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		checks++;
		if (g !== e) begin
			errCount++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_sys);
		{cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hf};
		do @(posedge clk_sys); while (ack !== 1);
		q = rdat;
		{cyc, stb} <= 2'b00;
	endtask
	task automatic op(input logic [7:0] f, input int s, input int r);
		int s0, r0;
		s0 = nS;
		r0 = nR;
		tpg_prog_model_i.send(f);
		repeat (40) @(posedge clk_sys);
		chk("strobes", s, nS - s0);
		if (r >= 0) chk("refusals", r, nR - r0);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, errCount);
		if (errCount == 0 && checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		#500us;
		errCount++;
		conclude();
	end
	initial begin
		logic [31:0] q;
		logic [11:0] p;
		int          k, a0;
		void'($urandom(27406));
		repeat (20) @(posedge clk_sys);
		resetn <= 1;
		repeat (4) @(posedge clk_sys);
		wb(0, tpg_pkg::OFS_PORT_ENABLE, 0, q);
		chk("enable", 0, q);
		wb(0, tpg_pkg::OFS_STATUS, 0, q);
		chk("lock", 1, q[tpg_pkg::ST_LOCK_BIT]);
		wb(0, 8'h40, 0, q);
		chk("unmapped", 0, q);
		wb(1, tpg_pkg::OFS_PORT_ENABLE, 1, q);
		wb(0, tpg_pkg::OFS_PORT_ENABLE, 0, q);
		chk("enable", 1, q);
		chk("oe", 0, oe);
		op(8'h10, 0, -1);
		chk("oe", 1, oe);
		foreach (lk[i]) op(lk[i], 0, 1);
		op(8'h60, 1, 0);
		chk("code", tpg_pkg::OP_CHIP_ERASE, code);
		wb(0, tpg_pkg::OFS_STATUS, 0, q);
		chk("lock", 0, q[tpg_pkg::ST_LOCK_BIT]);
		chk("blank", 1, q[tpg_pkg::ST_BLANK_BIT]);
		op(8'h80, 1, 0);
		op(8'h20, 1, 0);
		chk("cfg", tpg_pkg::CFG_BLANK_VALUE, rx);
		op(8'h00, 0, 0);
		chk("mem", tpg_pkg::MEM_BLANK_VALUE, rx);
		p = 12'($urandom);
		prot <= p;
		for (int i = 0; i < 6; i++) begin
			k = (i < 2) ? 11 + i : $urandom_range(10);
			op({4'h4, k[3:0]}, eraseOk(p, k), !eraseOk(p, k));
		end
		a0 = nA;
		tpg_prog_model_i.send(8'h35);
		repeat (6) @(posedge clk_sys);
		devRst <= 1;
		repeat (10) @(posedge clk_sys);
		chk("aborts", 1, nA - a0);
		wb(0, tpg_pkg::OFS_PORT_ENABLE, 0, q);
		chk("enable", 0, q);
		op(8'h20, 0, -1);
		devRst <= 0;
		ded <= 1;
		op(8'h10, 0, -1);
		a0 = nA;
		tpg_prog_model_i.send(8'h35);
		repeat (6) @(posedge clk_sys);
		devRst <= 1;
		repeat (40) @(posedge clk_sys);
		chk("aborts", 0, nA - a0);
		op(8'h20, 1, 0);
		{term, ded} <= 2'b10;
		repeat (4) @(posedge clk_sys);
		chk("active", 1, act);
		devRst <= 0;
		conclude();
	end
endmodule
